/* include/fpr_pkg.sv */
// Constants shared by the coprocessor register file and its users.
package fpr_pkg;

  localparam int          WORD_W       = 32;
  localparam int          NUM_REGS     = 32;
  localparam int          IDX_W        = 5;
  localparam int          OPC_W        = 6;
  localparam int          ADDR_W       = 32;

  // Coprocessor select window in the upper half of the address.
  localparam int          SEL_LSB      = 16;
  localparam logic [15:0] SEL_LOW      = 16'hC000;
  localparam logic [15:0] SEL_HIGH     = 16'hC1FF;

  // Operand and opcode fields of the access address.
  localparam int          OPC_LSB      = 10;
  localparam int          SRC1_HI_LSB  = 7;
  localparam int          SRC1_HI_W    = 3;
  localparam int          DST_LSB      = 2;
  localparam int          SRC1_LO_LSB  = 0;
  localparam int          SRC1_LO_W    = 2;

  // Register-file opcodes; every other opcode goes to the arithmetic units.
  localparam logic [5:0]  OPC_LOAD_S   = 6'h01;
  localparam logic [5:0]  OPC_LOAD_D   = 6'h02;
  localparam logic [5:0]  OPC_STORE_S  = 6'h03;
  localparam logic [5:0]  OPC_STORE_DH = 6'h04;
  localparam logic [5:0]  OPC_STORE_DL = 6'h05;
  localparam logic [5:0]  OPC_CTX_LOAD = 6'h06;
  localparam logic [5:0]  OPC_CTX_STOR = 6'h07;
  localparam logic [5:0]  OPC_REV_STOR = 6'h08;
  localparam int          OPC_DBL_BIT  = 5;

  // Process context layout.
  localparam int          ACC_LSB      = 0;
  localparam int          ACC_W        = 10;
  localparam int          RND_LSB      = 10;
  localparam int          RND_W        = 2;
  localparam int          MASK_LSB     = 16;
  localparam int          MASK_W       = 10;
  localparam logic [1:0]  RND_NEAREST  = 2'h0;
  localparam logic [31:0] CTX_RESET    = 32'h03FF0000;

  // Revision level is returned in bits 15:8 of a revision read.
  localparam int          REV_LSB      = 8;
  localparam int          REV_W        = 8;

  localparam logic [4:0]  BUS_INDEX    = 5'h00;
  localparam logic [4:0]  PAIR_LSW     = 5'h01;

endpackage : fpr_pkg

/* hdl/fpr_regfile.sv */
// Architectural register file and process context of the coprocessor.
`timescale 1ns/10ps
// Notes on behaviour
// - Thirty-two single-precision registers, index 0 to 31.
// - Even-indexed pairs form sixteen double registers.
// - Pair keeps high word even, low odd.
// - One writable 32-bit process context register.
// - Context read returns settings and status flags.
// - Context holds rounding, mask, accumulated exception fields.
// - Writing 003FF0000h: nearest, all masked, cleared.
// - Host data bus supplies transfer and arithmetic operands.
// - Five-bit operand fields come from the access address.
// - First source zero takes operand from data bus.
module fpr_regfile #(
  parameter logic [7:0] REVISION = 8'h5A  // Arbitrary revision code.
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       acc_valid_i,
  input  wire logic [fpr_pkg::ADDR_W-1:0] acc_addr_i,
  input  wire logic [fpr_pkg::WORD_W-1:0] data_i,
  input  wire logic                       res_valid_i,
  input  wire logic [fpr_pkg::IDX_W-1:0]  res_dest_i,
  input  wire logic [fpr_pkg::WORD_W-1:0] res_data_i,
  input  wire logic [fpr_pkg::ACC_W-1:0]  exc_event_i,
  output logic      [fpr_pkg::WORD_W-1:0] rd_data_o,
  output logic                            rd_valid_o,
  output logic                            op_valid_o,
  output logic      [fpr_pkg::OPC_W-1:0]  op_code_o,
  output logic                            op_double_o,
  output logic      [fpr_pkg::IDX_W-1:0]  op_dest_o,
  output logic      [2*fpr_pkg::WORD_W-1:0] op_a_o,
  output logic      [2*fpr_pkg::WORD_W-1:0] op_b_o,
  output logic      [fpr_pkg::WORD_W-1:0] context_o
);
  import fpr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [NUM_REGS-1:0][WORD_W-1:0] regs;
    logic [WORD_W-1:0]               ctx;
    logic [WORD_W-1:0]               rdata;
    logic                            rvalid;
    logic                            opv;
    logic [OPC_W-1:0]                opc;
    logic                            opd;
    logic [IDX_W-1:0]                opdst;
    logic [2*WORD_W-1:0]             opa;
    logic [2*WORD_W-1:0]             opb;
  } fpr_state_t;

  // Context comes out of reset with nearest rounding, every exception
  // masked and no flag set, so a host that skips its set-up still gets
  // quiet default behaviour.
  localparam fpr_state_t STATE_RESET = '{
    regs:   '0,
    ctx:    CTX_RESET,
    rdata:  '0,
    rvalid: 1'b0,
    opv:    1'b0,
    opc:    '0,
    opd:    1'b0,
    opdst:  '0,
    opa:    '0,
    opb:    '0
  };

  fpr_state_t q;
  fpr_state_t next_q;

  // Even register of the pair that holds the given index.
  function automatic logic [IDX_W-1:0] pair_base(input logic [IDX_W-1:0] idx);
    pair_base = idx & ~PAIR_LSW;
  endfunction : pair_base

  // Only the upper half selects the coprocessor; the lower half is the
  // instruction and means nothing outside the window.
  function automatic logic in_window(input logic [ADDR_W-1:0] a);
    logic [$bits(SEL_LOW)-1:0] sel;
    sel = a[SEL_LSB +: $bits(SEL_LOW)];
    in_window = (sel >= SEL_LOW) && (sel <= SEL_HIGH);
  endfunction : in_window

  // Joins a most and a least significant word into one double operand.
  function automatic logic [2*WORD_W-1:0] pair_join(
    input logic [WORD_W-1:0] msw,
    input logic [WORD_W-1:0] lsw
  );
    pair_join = {msw, lsw};
  endfunction : pair_join

  ////////////////////////////////////////////////////////////////////////////
  // Decoded fields of the access address; they mean nothing unless the
  // access is taken.
  logic [IDX_W-1:0]    src1;
  logic [IDX_W-1:0]    dst;
  logic [OPC_W-1:0]    opc;
  logic [IDX_W-1:0]    s_even;
  logic [IDX_W-1:0]    d_even;
  logic                from_bus;
  logic [WORD_W-1:0]   src1_word;
  logic [2*WORD_W-1:0] src1_pair;
  logic                taken;

  // The first source is split so that block moves can step the low bits.
  assign src1 = {acc_addr_i[SRC1_HI_LSB +: SRC1_HI_W],
                 acc_addr_i[SRC1_LO_LSB +: SRC1_LO_W]};
  assign dst = acc_addr_i[DST_LSB +: IDX_W];
  assign opc = acc_addr_i[OPC_LSB +: OPC_W];
  assign s_even = pair_base(src1);
  assign d_even = pair_base(dst);

  // Index zero never reaches register zero as a first source.
  assign from_bus = (src1 == BUS_INDEX);
  assign src1_word = from_bus ? data_i : q.regs[src1];
  // A double bus operand takes its low word from register one, since the
  // bus carries only one word per access; register one is left untouched.
  assign src1_pair = from_bus ? pair_join(data_i, q.regs[PAIR_LSW]) :
                     pair_join(q.regs[s_even],
                               q.regs[s_even | PAIR_LSW]);

  // Addresses outside the select window belong to other devices.
  assign taken = acc_valid_i && in_window(acc_addr_i);

  // Read and dispatch strobes are pulses: cleared every cycle, set only by
  // the access that asks for them. Data outputs keep their last value.
  always_comb begin
    next_q = q;
    next_q.rvalid = 1'b0;
    next_q.opv = 1'b0;
    if (res_valid_i) begin
      next_q.regs[res_dest_i] = res_data_i;
    end
    // A host access comes after the result write so that it wins when
    // both name the same register in one cycle.
    if (taken) begin
      case (opc)
        OPC_LOAD_S: begin
          next_q.regs[dst] = src1_word;
        end
        OPC_LOAD_D: begin
          // Destination index is forced even; the odd partner gets the LSW.
          next_q.regs[d_even] = src1_pair[WORD_W +: WORD_W];
          next_q.regs[d_even | PAIR_LSW] = src1_pair[0 +: WORD_W];
        end
        OPC_STORE_S: begin
          next_q.rdata = q.regs[dst];
          next_q.rvalid = 1'b1;
        end
        OPC_STORE_DH: begin
          // A double goes out in two accesses, one word each.
          next_q.rdata = q.regs[d_even];
          next_q.rvalid = 1'b1;
        end
        OPC_STORE_DL: begin
          next_q.rdata = q.regs[d_even | PAIR_LSW];
          next_q.rvalid = 1'b1;
        end
        OPC_CTX_LOAD: begin
          // Whole word is stored, so 03FF0000h gives nearest and all masked.
          next_q.ctx = data_i;
        end
        OPC_CTX_STOR: begin
          // Settings and flags come back together for a context save.
          next_q.rdata = q.ctx;
          next_q.rvalid = 1'b1;
        end
        OPC_REV_STOR: begin
          // Only the revision byte is set; the other bits read as zero.
          next_q.rdata = '0;
          next_q.rdata[REV_LSB +: REV_W] = REVISION;
          next_q.rvalid = 1'b1;
        end
        default: begin
          // Operands are fetched now, so a later write to the same register
          // cannot change what the arithmetic units see.
          next_q.opv = 1'b1;
          next_q.opc = opc;
          next_q.opd = opc[OPC_DBL_BIT];
          next_q.opdst = opc[OPC_DBL_BIT] ? d_even : dst;
          next_q.opa = opc[OPC_DBL_BIT] ? src1_pair :
                       {{WORD_W{1'b0}}, src1_word};
          next_q.opb = opc[OPC_DBL_BIT] ?
                       pair_join(q.regs[d_even], q.regs[d_even | PAIR_LSW]) :
                       {{WORD_W{1'b0}}, q.regs[dst]};
        end
      endcase
    end
    // Applied after a context write so a same-cycle exception survives it.
    next_q.ctx[ACC_LSB +: ACC_W] = next_q.ctx[ACC_LSB +: ACC_W] |
                                   exc_event_i;
  end

  // Reset only loads the constant state; all decoding stays in the
  // combinational process above.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= STATE_RESET;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every output is a flip-flop, so nothing on the host bus reaches an
  // output within the cycle in which it is presented.
  assign rd_data_o = q.rdata;
  assign rd_valid_o = q.rvalid;
  assign op_valid_o = q.opv;
  assign op_code_o = q.opc;
  assign op_double_o = q.opd;
  assign op_dest_o = q.opdst;
  assign op_a_o = q.opa;
  assign op_b_o = q.opb;
  assign context_o = q.ctx;

endmodule : fpr_regfile

/* tb/fpr_regfile_assertions.sv */
// Port-level checker for the coprocessor register file.
`timescale 1ns/10ps
module fpr_regfile_assertions
  import fpr_pkg::*;
#(parameter logic [7:0] REVISION = 8'h5A) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        acc_valid_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic [31:0] data_i,
  input wire logic [9:0]  exc_event_i,
  input wire logic [31:0] rd_data_o,
  input wire logic        rd_valid_o,
  input wire logic        op_valid_o,
  input wire logic        op_double_o,
  input wire logic [5:0]  op_code_o,
  input wire logic [4:0]  op_dest_o,
  input wire logic [63:0] op_a_o,
  input wire logic [63:0] op_b_o,
  input wire logic [31:0] context_o
);
  wire [15:0] sl = acc_addr_i[31:16];
  wire sel = acc_valid_i && sl >= SEL_LOW && sl <= SEL_HIGH;
  wire [5:0] opc = acc_addr_i[15:10];
  wire ar = sel && (opc == 6'h00 || opc > 6'h08);
  wire s0 = {acc_addr_i[9:7], acc_addr_i[1:0]} == BUS_INDEX;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ctx_read_a: assert property (sel && opc == OPC_CTX_STOR |=>
    rd_valid_o && rd_data_o == $past(context_o)) else $error("ctx read");
  rev_read_a: assert property (sel && opc == OPC_REV_STOR |=>
    rd_data_o == {16'h0, REVISION, 8'h0}) else $error("revision read");
  ctx_write_a: assert property (sel && opc == OPC_CTX_LOAD &&
    exc_event_i == 10'h0 |=> context_o == $past(data_i)) else $error("ctx wr");
  exc_acc_a: assert property (exc_event_i != 10'h0 |=>
    (context_o[9:0] & $past(exc_event_i)) == $past(exc_event_i))
    else $error("exception flags");
  no_sel_a: assert property (!sel |=> !rd_valid_o && !op_valid_o)
    else $error("ignored access answered");
  load_quiet_a: assert property (sel && opc == OPC_LOAD_S |=>
    !rd_valid_o && !op_valid_o) else $error("load answered");
  dispatch_a: assert property (ar |=> op_valid_o &&
    op_code_o == $past(opc) && op_dest_o ==
    ($past(acc_addr_i[6:2]) & {4'hF, ~$past(opc[5])})) else $error("dispatch");
  bus_op_a: assert property (ar && s0 && !opc[5] |=>
    op_a_o == {32'h0, $past(data_i)}) else $error("bus operand");
  dbl_flag_a: assert property (ar |=>
    op_double_o == $past(opc[5])) else $error("double flag");
  bus_msw_a: assert property (ar && s0 && opc[5] |=>
    op_a_o[63:32] == $past(data_i)) else $error("bus double operand");
  single_b_a: assert property (ar && !opc[5] |=>
    op_b_o[63:32] == 32'h0) else $error("single second operand");
endmodule : fpr_regfile_assertions
bind fpr_regfile fpr_regfile_assertions #(.REVISION(REVISION)) u_chk (.*);

/* tb/fpr_host.sv */
// Host core model issuing memory-mapped coprocessor accesses.
`timescale 1ns/10ps
module fpr_host
  import fpr_pkg::*;
(
  input  wire logic  clk_i,
  output logic       acc_valid_o = 1'b0,
  output logic[31:0] acc_addr_o = 32'h0,
  output logic[31:0] data_o = 32'h0
);
  task automatic acc(input logic [15:0] sl, input logic [5:0] op,
    input logic [4:0] d, input logic [4:0] s, input logic [31:0] w);
    @(posedge clk_i);
    acc_valid_o <= 1'b1;
    acc_addr_o <= {sl, op, s[4:2], d, s[1:0]};
    data_o <= w;
    @(posedge clk_i);
    acc_valid_o <= 1'b0;
    // A released bus must not keep looking like valid data.
    data_o <= ~w;
  endtask : acc
  task automatic power_up();
    acc(16'hC000, OPC_CTX_LOAD, 5'h0, 5'h0, 32'hB8000000);
    acc(16'hC000, OPC_REV_STOR, 5'h0, 5'h1, 32'h0);
    acc(16'hC000, OPC_CTX_LOAD, 5'h0, 5'h0, 32'h64000000);
    acc(16'hC000, OPC_CTX_LOAD, 5'h0, 5'h0, 32'hA0000000);
    acc(16'hC000, OPC_CTX_LOAD, 5'h0, 5'h0, 32'h30000000);
  endtask : power_up
endmodule : fpr_host

/* tb/fpr_regfile_test.sv */
// Self-checking bench for the coprocessor register file.
`timescale 1ns/10ps
module fpr_regfile_test;
  import fpr_pkg::*;
  logic clk_i = 0, rst_i = 1, res_valid_i = 0, acc_valid_i;
  logic rd_valid_o, op_valid_o, op_double_o;
  logic [31:0] acc_addr_i, data_i, res_data_i = 0, rd_data_o, context_o, w;
  logic [31:0] seed = 67090, regs[32], exp_q[$];
  logic [4:0] res_dest_i = 0, op_dest_o;
  logic [9:0] exc_event_i = 0;
  logic [5:0] op_code_o;
  logic [63:0] op_a_o, op_b_o;
  int n_errors = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  fpr_host u_fpr_host (.clk_i(clk_i), .acc_valid_o(acc_valid_i),
    .acc_addr_o(acc_addr_i), .data_o(data_i));
  fpr_regfile u_fpr_regfile (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [5:0] op, input logic [4:0] d, logic [31:0] e);
    exp_q.push_back(e);
    u_fpr_host.acc(16'hC000, op, d, 5'h1, 32'h0);
  endtask : rd
  task automatic wrap_up();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) if (rd_valid_o === 1'b1)
    chk("rd_data", exp_q.pop_front(), rd_data_o);
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OPC_CTX_STOR, 5'h0, CTX_RESET);
    exp_q.push_back(32'h00005A00);
    u_fpr_host.power_up();
    rd(OPC_CTX_STOR, 5'h0, 32'h30000000);
    u_fpr_host.acc(16'hC000, OPC_CTX_LOAD, 5'h0, 5'h0, 32'h03FF0000);
    rd(OPC_CTX_STOR, 5'h0, 32'h03FF0000);
    $display("Test context done");
    for (int i = 0; i < 32; i++) begin
      regs[i] = rnd();
      u_fpr_host.acc(16'hC000, OPC_LOAD_S, 5'(i), 5'h0, regs[i]);
    end
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      regs[i*9] = w;
      @(posedge clk_i);
      res_valid_i <= 1'b1;
      res_dest_i <= 5'(i*9);
      res_data_i <= w;
    end
    @(posedge clk_i) res_valid_i <= 1'b0;
    u_fpr_host.acc(16'hC000, OPC_LOAD_D, 5'hB, 5'h2, rnd());
    regs[10] = regs[2];
    regs[11] = regs[3];
    w = rnd();
    u_fpr_host.acc(16'hC000, OPC_LOAD_D, 5'h10, 5'h0, w);
    regs[16] = w;
    regs[17] = regs[1];
    // Outside the select window the write must vanish.
    u_fpr_host.acc(16'hC200, OPC_LOAD_S, 5'h6, 5'h0, rnd());
    for (int i = 0; i < 32; i++) rd(OPC_STORE_S, 5'(i), regs[i]);
    for (int i = 2; i < 32; i += 6) begin
      rd(OPC_STORE_DH, 5'(i + 1), regs[i]);
      rd(OPC_STORE_DL, 5'(i), regs[i + 1]);
    end
    $display("Test registers done");
    w = rnd();
    @(posedge clk_i) exc_event_i <= w[9:0];
    @(posedge clk_i) exc_event_i <= 10'h0;
    rd(OPC_CTX_STOR, 5'h0, 32'h03FF0000 | w[9:0]);
    u_fpr_host.acc(16'hC000, 6'h09, 5'h4, 5'h0, rnd());
    u_fpr_host.acc(16'hC000, 6'h21, 5'h5, 5'h0, rnd());
    u_fpr_host.acc(16'hC000, 6'h00, 5'h3, 5'h6, 32'h0);
    repeat (3) @(posedge clk_i);
    chk("pending reads", 32'h0, 32'(exp_q.size()));
    $display("Test dispatch done");
    wrap_up();
  end
endmodule : fpr_regfile_test
